//--- hdl/dfm_core.sv
// Oscillator control: locked loop integrator, modulator and clock requests
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module dfm_core
  import dfm_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rdata,
  input wire logic crystal_one_clock,
  input wire logic trimmed_ref_clock,
  input wire logic crystal_two_clock,
  input wire logic very_low_osc_clock,
  input wire logic irq_entry,
  input wire dfm_req_t clk_req,
  input wire logic wdt_src_avail,
  input wire logic wdt_src_clock,
  output logic wdt_clock,
  output logic [2:0] osc_range_select,
  output logic [4:0] osc_tap_eff,
  output logic osc_divided_clock,
  output logic loop_ref_tick,
  output logic aux_clk_off,
  output logic master_clk_off,
  output logic subsystem_clk_off
);
  // ==========================================================
  // Functions
  function automatic logic [4:0] ref_div_val(input logic [2:0] code);
    case (code)
      3'h0: ref_div_val = 5'h01;
      3'h1: ref_div_val = 5'h02;
      3'h2: ref_div_val = 5'h04;
      3'h3: ref_div_val = 5'h08;
      3'h4: ref_div_val = 5'h0C;
      default: ref_div_val = 5'h10;
    endcase
  endfunction

  function automatic logic [5:0] pre_div_val(input logic [2:0] code);
    case (code)
      3'h0: pre_div_val = 6'h01;
      3'h1: pre_div_val = 6'h02;
      3'h2: pre_div_val = 6'h04;
      3'h3: pre_div_val = 6'h08;
      3'h4: pre_div_val = 6'h10;
      default: pre_div_val = 6'h20;
    endcase
  endfunction

  // Status bits sit at fixed positions, whatever the struct order
  function automatic logic [3:0] sr_pack(input dfm_sr_t s);
    sr_pack = 4'h0;
    sr_pack[SR_LOOP_DIS] = s.loop_disable_flag;
    sr_pack[SR_SYSGEN_OFF] = s.sysgen_off_flag;
    sr_pack[SR_CPU_OFF] = s.processor_clock_off;
    sr_pack[SR_OSC_OFF] = s.oscillator_off_flag;
  endfunction

  // Multiplier zero acts as two, so feedback never divides by one
  function automatic logic [10:0] fb_div_val(input logic [MULT_W-1:0] m);
    if (m == '0) begin
      fb_div_val = 11'h002;
    end else begin
      fb_div_val = {1'b0, m} + 11'h001;
    end
  endfunction

  // ==========================================================
  // Control and status registers
  logic [2:0] rsel_ff, nxt_rsel;
  logic modulator_disable_ff, nxt_modulator_disable;
  logic [2:0] pre_ff, nxt_pre;
  logic [MULT_W-1:0] mult_ff, nxt_mult;
  logic [2:0] refsel_ff, nxt_refsel;
  logic [2:0] refdiv_ff, nxt_refdiv;
  dfm_sr_t sr_ff, nxt_sr;
  logic [9:0] integ_ff, nxt_integ;
  logic [15:0] rdata_ff, nxt_rdata;
  logic [4:0] tap;
  logic [4:0] modv;
  logic loop_run;

  assign tap = integ_ff[9:5];
  assign modv = integ_ff[4:0];
  // Either off flag freezes the tap where it stands
  assign loop_run = !(sr_ff.loop_disable_flag || sr_ff.sysgen_off_flag);

  always_comb begin
    nxt_rsel = rsel_ff;
    nxt_modulator_disable = modulator_disable_ff;
    nxt_pre = pre_ff;
    nxt_mult = mult_ff;
    nxt_refsel = refsel_ff;
    nxt_refdiv = refdiv_ff;
    nxt_sr = sr_ff;
    nxt_rdata = 16'h0000;
    if (wr_en) begin
      case (addr)
        ADDR_CTL1: begin
          nxt_rsel = wdata[RSEL_LSB +: 3];
          nxt_modulator_disable = wdata[MODULATOR_DISABLE_BIT];
        end
        ADDR_CTL2: begin
          nxt_pre = wdata[PRE_LSB +: 3];
          nxt_mult = wdata[MULT_W-1:0];
        end
        ADDR_CTL3: begin
          nxt_refsel = wdata[REFSEL_LSB +: 3];
          nxt_refdiv = wdata[REFDIV_LSB +: 3];
        end
        ADDR_SR: begin
          nxt_sr.loop_disable_flag = wdata[SR_LOOP_DIS];
          nxt_sr.sysgen_off_flag = wdata[SR_SYSGEN_OFF];
          nxt_sr.processor_clock_off = wdata[SR_CPU_OFF];
          nxt_sr.oscillator_off_flag = wdata[SR_OSC_OFF];
        end
        default: ;
      endcase
    end

    // Interrupt entry wins over a same-cycle write
    if (irq_entry) begin
      nxt_sr.sysgen_off_flag = 1'b0;
      nxt_sr.processor_clock_off = 1'b0;
      nxt_sr.oscillator_off_flag = 1'b0;
    end

    if (rd_en) begin
      case (addr)
        ADDR_CTL0: nxt_rdata = {3'h0, tap, modv, 3'h0};
        ADDR_CTL1: nxt_rdata = {9'h000, rsel_ff, 3'h0, modulator_disable_ff};
        ADDR_CTL2: nxt_rdata = {1'b0, pre_ff, 2'h0, mult_ff};
        ADDR_CTL3: nxt_rdata = {9'h000, refsel_ff, 1'b0, refdiv_ff};
        ADDR_SR: nxt_rdata = {12'h000, sr_pack(sr_ff)};
        ADDR_REQ: nxt_rdata = {13'h0000, clk_req};
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rsel_ff <= RSEL_RST;
      modulator_disable_ff <= 1'b0;
      pre_ff <= PRE_RST;
      mult_ff <= MULT_RST;
      refsel_ff <= REFSEL_RST;
      refdiv_ff <= REFDIV_RST;
      sr_ff <= '0;
      rdata_ff <= 16'h0000;
    end else begin
      rsel_ff <= nxt_rsel;
      modulator_disable_ff <= nxt_modulator_disable;
      pre_ff <= nxt_pre;
      mult_ff <= nxt_mult;
      refsel_ff <= nxt_refsel;
      refdiv_ff <= nxt_refdiv;
      sr_ff <= nxt_sr;
      rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================
  // Reference path: select, edge detect, divide by n
  // Reference pins are sampled as synchronous levels; edge taken here
  logic ref_sel, ref_prev_ff, nxt_ref_prev;
  logic [4:0] refcnt_ff, nxt_refcnt;
  logic ref_tick;

  always_comb begin
    case (refsel_ff)
      REF_XT1: ref_sel = crystal_one_clock;
      REF_TRIM: ref_sel = trimmed_ref_clock;
      REF_XT2: ref_sel = crystal_two_clock;
      // Unused codes fall back to the trimmed source
      default: ref_sel = trimmed_ref_clock;
    endcase
    nxt_ref_prev = ref_sel;
    nxt_refcnt = refcnt_ff;
    ref_tick = 1'b0;
    if (ref_sel && !ref_prev_ff) begin
      if (refcnt_ff >= ref_div_val(refdiv_ff) - 5'h01) begin
        nxt_refcnt = 5'h00;
        ref_tick = 1'b1;
      end else begin
        nxt_refcnt = refcnt_ff + 5'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ref_prev_ff <= 1'b0;
      refcnt_ff <= 5'h00;
    end else begin
      ref_prev_ff <= nxt_ref_prev;
      refcnt_ff <= nxt_refcnt;
    end
  end

  // ==========================================================
  // Oscillator model: output clock is core_clk gated per tap period
  // Modulator frame counter and output divider by D
  logic [4:0] frame_ff, nxt_frame;
  logic [5:0] phase_ff, nxt_phase;
  logic [5:0] precnt_ff, nxt_precnt;
  logic [10:0] fbcnt_ff, nxt_fbcnt;
  logic div_ff, nxt_div;
  logic osc_edge;
  logic [5:0] period;
  logic use_hi;
  logic [10:0] fb_div;

  always_comb begin
    // Higher tap = shorter period in this behavioural model
    use_hi = !modulator_disable_ff && (modv != 5'h00) && (tap != TAP_MAX)
             && (frame_ff < modv);
    osc_tap_eff = use_hi ? tap + 5'h01 : tap;
    period = 6'h20 - {1'b0, osc_tap_eff};
    osc_edge = (phase_ff >= period - 6'h01);
    nxt_phase = osc_edge ? 6'h00 : phase_ff + 6'h01;
    nxt_frame = frame_ff;
    nxt_precnt = precnt_ff;
    nxt_div = div_ff;
    if (osc_edge) begin
      nxt_frame = (frame_ff == FRAME_LAST) ? 5'h00 : frame_ff + 5'h01;
      if (precnt_ff >= pre_div_val(pre_ff) - 6'h01) begin
        nxt_precnt = 6'h00;
        nxt_div = 1'b1;
      end else begin
        nxt_precnt = precnt_ff + 6'h01;
        nxt_div = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      frame_ff <= 5'h00;
      phase_ff <= 6'h00;
      precnt_ff <= 6'h00;
      div_ff <= 1'b0;
    end else begin
      frame_ff <= nxt_frame;
      phase_ff <= nxt_phase;
      precnt_ff <= nxt_precnt;
      div_ff <= nxt_div;
    end
  end

  // ==========================================================
  // Locked loop state machine and integrator
  dfm_loop_state_t st_ff, nxt_st;
  logic ref_pend_ff, nxt_ref_pend;
  logic fb_tick;
  logic ctl0_wr_ff, nxt_ctl0_wr;
  logic [9:0] ctl0_data_ff, nxt_ctl0_data;
  logic ctl0_take;

  always_comb begin
    fb_div = fb_div_val(mult_ff);
    fb_tick = 1'b0;
    ctl0_take = wr_en && (addr == ADDR_CTL0) && !loop_run;
    nxt_fbcnt = fbcnt_ff;
    nxt_st = st_ff;
    nxt_integ = integ_ff;
    nxt_ref_pend = ref_pend_ff || ref_tick;
    nxt_ctl0_wr = ctl0_wr_ff;
    nxt_ctl0_data = ctl0_data_ff;
    // Held off while the loop owns the integrator
    if (ctl0_take) begin
      nxt_ctl0_wr = 1'b1;
      nxt_ctl0_data = {wdata[TAP_LSB +: 5], wdata[MOD_LSB +: 5]};
    end
    if (osc_edge && div_ff) begin
      if (fbcnt_ff >= fb_div - 11'h001) begin
        nxt_fbcnt = 11'h000;
        fb_tick = 1'b1;
      end else begin
        nxt_fbcnt = fbcnt_ff + 11'h001;
      end
    end

    case (st_ff)
      LS_IDLE: nxt_st = loop_run ? LS_RUN : LS_HOLD;
      LS_RUN: begin
        if (!loop_run) begin
          nxt_st = LS_HOLD;
        end else if (fb_tick) begin
          // Reference seen since last feedback: oscillator slow
          if (ref_pend_ff || ref_tick) begin
            if (integ_ff != 10'h3FF) nxt_integ = integ_ff + 10'h001;
          end else if (integ_ff != 10'h000) begin
            nxt_integ = integ_ff - 10'h001;
          end
          nxt_ref_pend = 1'b0;
        end
      end
      LS_HOLD: begin
        nxt_ref_pend = 1'b0;
        if (loop_run) nxt_st = LS_RUN;
      end
      default: nxt_st = LS_IDLE;
    endcase

    // Write lands on the next oscillator edge only
    if (osc_edge && ctl0_wr_ff) begin
      nxt_integ = ctl0_data_ff;
      // A write in this same cycle stays pending
      nxt_ctl0_wr = ctl0_take;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fbcnt_ff <= 11'h000;
      st_ff <= LS_IDLE;
      integ_ff <= {TAP_RST, 5'h00};
      ref_pend_ff <= 1'b0;
      ctl0_wr_ff <= 1'b0;
      ctl0_data_ff <= 10'h000;
    end else begin
      fbcnt_ff <= nxt_fbcnt;
      st_ff <= nxt_st;
      integ_ff <= nxt_integ;
      ref_pend_ff <= nxt_ref_pend;
      ctl0_wr_ff <= nxt_ctl0_wr;
      ctl0_data_ff <= nxt_ctl0_data;
    end
  end

  // ==========================================================
  // Outputs and clock requests
  // Each tap step needs n x 32 reference edges through the fb ratio
  assign loop_ref_tick = ref_tick;
  assign osc_divided_clock = div_ff;
  assign osc_range_select = rsel_ff;
  assign rdata = rdata_ff;

  // Requests override the off outputs; the stored bits stay as written
  assign master_clk_off = sr_ff.processor_clock_off && !clk_req.master;
  assign subsystem_clk_off = sr_ff.sysgen_off_flag && !clk_req.subsystem;
  assign aux_clk_off = sr_ff.oscillator_off_flag && !clk_req.aux;
  // Watchdog never loses its clock: fallback is the very-low source
  assign wdt_clock = wdt_src_avail ? wdt_src_clock : very_low_osc_clock;
endmodule
`default_nettype wire

//--- hdl/dfm_pkg.sv
// Package: constants and types of the oscillator control block
package dfm_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // Register index map (word addresses)
  localparam logic [3:0] ADDR_CTL0 = 4'h0;
  localparam logic [3:0] ADDR_CTL1 = 4'h1;
  localparam logic [3:0] ADDR_CTL2 = 4'h2;
  localparam logic [3:0] ADDR_CTL3 = 4'h3;
  localparam logic [3:0] ADDR_SR = 4'h4;
  localparam logic [3:0] ADDR_REQ = 4'h5;
  // Control word 0: tap [12:8], modulation [7:3]
  localparam int TAP_LSB = 8;
  localparam int MOD_LSB = 3;
  // Control word 1: range [6:4], modulator disable [0]
  localparam int RSEL_LSB = 4;
  localparam int MODULATOR_DISABLE_BIT = 0;
  // Control word 2: prescaler code [14:12], multiplier [9:0]
  localparam int PRE_LSB = 12;
  localparam int MULT_W = 10;
  // Control word 3: reference select [6:4], ref divider code [2:0]
  localparam int REFSEL_LSB = 4;
  localparam int REFDIV_LSB = 0;
  // Status word bits
  localparam int SR_LOOP_DIS = 0;
  localparam int SR_SYSGEN_OFF = 1;
  localparam int SR_CPU_OFF = 2;
  localparam int SR_OSC_OFF = 3;
  // Reset values, then reference select codes and limits
  localparam logic [2:0] RSEL_RST = 3'h2;
  localparam logic [4:0] TAP_RST = 5'h00;
  localparam logic [2:0] PRE_RST = 3'h1;
  localparam logic [2:0] REFDIV_RST = 3'h0;
  localparam logic [2:0] REFSEL_RST = 3'h0;
  localparam logic [MULT_W-1:0] MULT_RST = 10'h01F;
  localparam logic [2:0] REF_XT1 = 3'h0;
  localparam logic [2:0] REF_TRIM = 3'h2;
  localparam logic [2:0] REF_XT2 = 3'h5;
  localparam logic [4:0] TAP_MAX = 5'h1F;
  localparam logic [4:0] FRAME_LAST = 5'h1F;
  localparam logic [2:0] SRC_DIV = 3'h4;
  typedef struct packed {
    logic loop_disable_flag;
    logic sysgen_off_flag;
    logic processor_clock_off;
    logic oscillator_off_flag;
  } dfm_sr_t;
  typedef struct packed {
    logic aux;
    logic master;
    logic subsystem;
  } dfm_req_t;
  typedef enum logic [2:0] {
    LS_IDLE = 3'b001,
    LS_RUN = 3'b010,
    LS_HOLD = 3'b100
  } dfm_loop_state_t;
endpackage

//--- bench/dfm_peer.sv
// Partner model: reference oscillators, watchdog source and peripheral requests
`timescale 1ns/1ps
`default_nettype none
module dfm_peer
  import dfm_pkg::*;
(
  input wire logic core_clk,
  input wire dfm_req_t want,
  output logic crystal_one_clock,
  output logic trimmed_ref_clock,
  output logic crystal_two_clock,
  output logic very_low_osc_clock,
  output logic wdt_src_clock,
  output dfm_req_t clk_req
);
  // ====================
  // Sources toggle on the core grid: the block takes them as synchronous levels
  int tick_cnt = 0;
  initial begin
    crystal_one_clock = 1'b0;
    trimmed_ref_clock = 1'b0;
    crystal_two_clock = 1'b0;
    very_low_osc_clock = 1'b0;
    wdt_src_clock = 1'b0;
    clk_req = 3'h0;
  end
  // Periods in core cycles: 14, 8, 18, 46 and 6
  always @(posedge core_clk) begin
    tick_cnt <= tick_cnt + 1;
    if (tick_cnt % 7 == 6) crystal_one_clock <= ~crystal_one_clock;
    if (tick_cnt % 4 == 3) trimmed_ref_clock <= ~trimmed_ref_clock;
    if (tick_cnt % 9 == 8) crystal_two_clock <= ~crystal_two_clock;
    if (tick_cnt % 23 == 22) very_low_osc_clock <= ~very_low_osc_clock;
    if (tick_cnt % 3 == 2) wdt_src_clock <= ~wdt_src_clock;
    // Request raised after an edge, held until withdrawn
    clk_req <= want;
  end
endmodule
`default_nettype wire

//--- bench/dfm_core_sva.sv
// Checker: port properties of the oscillator control block
`timescale 1ns/1ps
`default_nettype none
module dfm_core_sva
  import dfm_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic irq_entry,
  input wire dfm_req_t clk_req,
  input wire logic wdt_src_avail,
  input wire logic wdt_src_clock,
  input wire logic very_low_osc_clock,
  input wire logic wdt_clock,
  input wire logic [2:0] osc_range_select,
  input wire logic [4:0] osc_tap_eff,
  input wire logic aux_clk_off,
  input wire logic master_clk_off,
  input wire logic subsystem_clk_off
);
  // ====================
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  chk_range_reset: assert property ($rose(resetn) |-> osc_range_select == RSEL_RST)
    else $error("range not at reset value");
  chk_tap_reset: assert property ($rose(resetn) |-> osc_tap_eff == TAP_RST)
    else $error("tap not at reset value");
  chk_range_write: assert property (
    wr_en && addr == ADDR_CTL1 |=> osc_range_select == $past(wdata[6:4]))
    else $error("range write lost");
  chk_aux_req: assert property (clk_req.aux |-> !aux_clk_off)
    else $error("aux request ignored");
  chk_master_req: assert property (clk_req.master |-> !master_clk_off)
    else $error("master request ignored");
  chk_sub_req: assert property (clk_req.subsystem |-> !subsystem_clk_off)
    else $error("subsystem request ignored");
  chk_irq_wake: assert property (
    irq_entry |=> !aux_clk_off && !master_clk_off && !subsystem_clk_off)
    else $error("off flags kept after irq");
  chk_wdt_fallback: assert property (
    !wdt_src_avail |-> wdt_clock == very_low_osc_clock)
    else $error("watchdog fallback missing");
  chk_wdt_direct: assert property (wdt_src_avail |-> wdt_clock == wdt_src_clock)
    else $error("watchdog source wrong");
endmodule
bind dfm_core dfm_core_sva u_dfm_core_sva (.core_clk, .resetn, .addr, .wdata, .wr_en,
  .irq_entry, .clk_req, .wdt_src_avail, .wdt_src_clock, .very_low_osc_clock, .wdt_clock,
  .osc_range_select, .osc_tap_eff, .aux_clk_off, .master_clk_off, .subsystem_clk_off);
`default_nettype wire

//--- bench/tb_dfm_core.sv
// Testbench: register, tap, reference and request scenarios
`timescale 1ns/1ps
`default_nettype none
module tb_dfm_core;
  import dfm_pkg::*;
  logic core_clk = 1'b0, resetn = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  logic irq_entry = 1'b0, wdt_src_avail = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata, v0, v1;
  logic x1, tr, x2, vlo, wsc, wclk, dclk, rtk, aoff, moff, soff;
  logic [2:0] rsel;
  logic [4:0] tap;
  dfm_req_t want = 3'h0, req;
  int err_count = 0, n_checks = 0, i, c, h, b, e;
  int nv[6] = '{1, 2, 4, 8, 12, 16};
  int pv[3] = '{14, 8, 18};
  logic [2:0] sv[3] = '{REF_XT1, REF_TRIM, REF_XT2};
  always #5 core_clk = ~core_clk;
  dfm_core u_dfm_core (.core_clk, .resetn, .addr, .wdata, .wr_en, .rd_en, .rdata,
    .crystal_one_clock(x1), .trimmed_ref_clock(tr), .crystal_two_clock(x2),
    .very_low_osc_clock(vlo), .irq_entry, .clk_req(req), .wdt_src_avail,
    .wdt_src_clock(wsc), .wdt_clock(wclk), .osc_range_select(rsel), .osc_tap_eff(tap),
    .osc_divided_clock(dclk), .loop_ref_tick(rtk), .aux_clk_off(aoff),
    .master_clk_off(moff), .subsystem_clk_off(soff));
  dfm_peer u_dfm_peer (.core_clk, .want, .crystal_one_clock(x1), .trimmed_ref_clock(tr),
    .crystal_two_clock(x2), .very_low_osc_clock(vlo), .wdt_src_clock(wsc), .clk_req(req));
  // ====================
  // Tasks
  task conclude;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask
  task rdc(input logic [3:0] a, input logic [15:0] m, input logic [15:0] x);
    rd(a, v0);
    chk(v0 & m, x);
  endtask
  // Tap applies at an oscillator edge, so wait for it
  task wtap(input logic [4:0] t);
    for (c = 0; c < 200 && tap !== t; c++) @(negedge core_clk);
    chk({11'h000, tap}, {11'h000, t});
  endtask
  task wtick(output int g);
    @(negedge core_clk);
    for (g = 1; g < 3000 && rtk !== 1'b1; g++) @(negedge core_clk);
    if (g == 3000) chk(16'h0000, 16'h0001);
  endtask
  // Counts cycles on the higher tap (h) and on neither tap (b)
  task scan(input logic [4:0] t);
    h = 0;
    b = 0;
    repeat (1000) begin
      @(negedge core_clk);
      h += int'(tap === t + 5'h01);
      b += int'(tap !== t && tap !== t + 5'h01);
    end
  endtask
  // ====================
  // Sequence
  initial begin
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    rdc(ADDR_CTL1, 16'h0070, 16'h0020);
    rdc(ADDR_CTL0, 16'h1F00, 16'h0000);
    rdc(ADDR_CTL2, 16'h73FF, 16'h101F);
    rdc(ADDR_CTL3, 16'h0077, 16'h0000);
    rdc(ADDR_SR, 16'h000F, 16'h0000);
    rdc(4'hF, 16'hFFFF, 16'h0000);
    for (i = 0; i < 8; i++) begin
      wr(ADDR_CTL1, 16'(i << 4));
      #1 chk({13'h0000, rsel}, 16'(i));
    end
    for (i = 0; i < 3; i++) begin
      wr(ADDR_CTL3, {9'h000, sv[i], 4'h0});
      wtick(c);
      wtick(c);
      chk(16'(c), 16'(pv[i]));
    end
    // Trimmed source period is 8 cycles, so divide-by-n ticks come n*8 cycles apart
    for (i = 0; i < 6; i++) begin
      wr(ADDR_CTL3, 16'h0020 | 16'(i));
      wtick(c);
      wtick(c);
      e = nv[i] * 8;
      chk(16'(c >= e - 1 && c <= e + 1), 16'h0001);
    end
    wr(ADDR_CTL1, 16'h0021);
    wr(ADDR_SR, 16'h0001);
    wr(ADDR_CTL0, 16'h0580);
    wtap(5'h05);
    scan(5'h05);
    chk(16'(h + b), 16'h0000);
    wr(ADDR_CTL1, 16'h0020);
    scan(5'h05);
    chk(16'(h > 0 && b == 0), 16'h0001);
    wr(ADDR_CTL0, 16'h0500);
    repeat (40) @(posedge core_clk);
    scan(5'h05);
    chk(16'(h + b), 16'h0000);
    wr(ADDR_CTL0, 16'h1F80);
    wtap(5'h1F);
    scan(5'h1F);
    chk(16'(h + b), 16'h0000);
    // Tap 31 gives an oscillator edge per cycle; D = 2 halves it
    e = 0;
    repeat (64) begin
      @(negedge core_clk);
      e += int'(dclk === 1'b1);
    end
    chk(16'(e), 16'h0020);
    wr(ADDR_CTL0, 16'h0580);
    wtap(5'h05);
    wr(ADDR_CTL2, 16'h0000);
    rd(ADDR_CTL0, v1);
    wr(ADDR_SR, 16'h0000);
    c = 0;
    for (i = 0; i < 20; i++) begin
      repeat (30) @(posedge core_clk);
      rd(ADDR_CTL0, v0);
      if (v0[12:3] !== v1[12:3]) c = 1;
    end
    chk(16'(c), 16'h0001);
    wr(ADDR_SR, 16'h0002);
    repeat (60) @(posedge core_clk);
    rd(ADDR_CTL0, v1);
    repeat (300) @(posedge core_clk);
    rdc(ADDR_CTL0, 16'hFFFF, v1);
    rdc(ADDR_CTL0, 16'hFFFF, v1);
    wr(ADDR_SR, 16'h000F);
    #1 chk({13'h0000, aoff, moff, soff}, 16'h0007);
    want <= 3'h2;
    repeat (3) @(posedge core_clk);
    #1 chk({13'h0000, aoff, moff, soff}, 16'h0005);
    rdc(ADDR_SR, 16'h000F, 16'h000F);
    want <= 3'h0;
    @(posedge core_clk);
    irq_entry <= 1'b1;
    @(posedge core_clk);
    irq_entry <= 1'b0;
    #1 chk({13'h0000, aoff, moff, soff}, 16'h0000);
    rdc(ADDR_SR, 16'h000F, 16'h0001);
    @(posedge core_clk);
    wdt_src_avail <= 1'b0;
    repeat (40) @(posedge core_clk);
    #1 chk({15'h0000, wclk}, {15'h0000, vlo});
    @(posedge core_clk);
    wdt_src_avail <= 1'b1;
    conclude;
  end
endmodule
`default_nettype wire
